/* rtl/mdfm_pkg.sv */
package mdfm_pkg;

   // retry intervals
   localparam int SLOW_RETRY_MS = 50;
   localparam int FAST_RETRY_MS = 5;
   localparam int CLK_KHZ = 200000;
   localparam int SLOW_RETRY_CYC = SLOW_RETRY_MS * CLK_KHZ;
   localparam int FAST_RETRY_CYC = FAST_RETRY_MS * CLK_KHZ;
   localparam int RETRY_W = 24;

   // overcurrent blanking after each phase-drive edge
   localparam int BLANK_NS = 200;
   localparam int CLK_PERIOD_NS = 5;
   localparam int BLANK_CYC = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BLANK_W = 8;

   // sleep-pin reset pulse: low at least this long
   localparam int RST_PULSE_NS = 1000;
   localparam int RST_PULSE_CYC =
      (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   localparam int PHASE_W = 6;

   // field codes
   localparam logic [2:0] UV_SEL_SLOW = 3'h0;
   localparam logic [2:0] UV_SEL_FAST = 3'h1;
   localparam logic [2:0] OC_RETRY_SLOW = 3'h0;
   localparam logic [2:0] OC_RETRY_FAST = 3'h1;
   localparam logic [2:0] OC_LATCHED = 3'h2;
   localparam logic [2:0] OC_REPORT = 3'h3;
   localparam logic [2:0] OC_DISABLED = 3'h7;
   localparam logic [1:0] TS_SLOW = 2'h0;
   localparam logic [1:0] TS_FAST = 2'h1;

   // reset values of configuration
   localparam logic [2:0] UV_SEL_RST = UV_SEL_SLOW;
   localparam logic [2:0] OC_MODE_RST = OC_RETRY_FAST;
   localparam logic [1:0] TS_MODE_RST = TS_FAST;

   typedef struct packed {
      logic mainSupplyUv;
      logic regInputUv;
      logic regOutputUv;
      logic chargePumpUv;
      logic senseRefUv;
      logic overcurrent;
      logic serialClockFault;
      logic serialAddrFault;
      logic thermalWarning;
      logic thermalShutdown;
   } mdfm_detect_type;

   typedef struct packed {
      logic       pinVariant;
      logic [2:0] uvRetrySelect;
      logic [2:0] overcurrentMode;
      logic       serialFaultMode;
      logic       thermalWarnReportEnable;
      logic [1:0] thermalShutdownMode;
      logic       senseRefUvEnable;
   } mdfm_config_type;

   typedef struct packed {
      logic powerOnFlag;
      logic faultFlag;
      logic undervoltageFlag;
      logic regInputUvFlag;
      logic regOutputUvFlag;
      logic chargePumpUvFlag;
      logic senseRefUvFlag;
      logic overcurrentFlag;
      logic serialFaultFlag;
      logic overTempFlag;
      logic thermalWarningFlag;
      logic thermalShutdownFlag;
   } mdfm_status_type;

endpackage : mdfm_pkg

/* rtl/mdfm_retry_timer.sv */
`timescale 1ns/1ps
// holds protection until the condition has been absent for a full interval
module mdfm_retry_timer
   import mdfm_pkg::*;
(
   input wire logic clk,
   input wire logic rstSyncB,
   input wire logic clkEn,
   input wire logic condition,
   input wire logic useFast,
   input wire logic [RETRY_W-1:0] slowCycles,
   input wire logic [RETRY_W-1:0] fastCycles,
   output logic holdOff
);

   logic [RETRY_W-1:0] count_q;
   logic active_q;
   logic [RETRY_W-1:0] limit;

   assign limit = useFast ? fastCycles : slowCycles;
   assign holdOff = condition | active_q;

   always_ff @(posedge clk or negedge rstSyncB) begin
      if (!rstSyncB) begin
         count_q <= '0;
         active_q <= 1'b0;
      end else if (clkEn) begin
         if (condition) begin
            // reappearing condition restarts the wait
            count_q <= '0;
            active_q <= 1'b1;
         end else if (active_q) begin
            if (count_q >= limit - 1'b1) begin
               active_q <= 1'b0;
               count_q <= '0;
            end else begin
               count_q <= count_q + 1'b1;
            end
         end
      end
   end

endmodule : mdfm_retry_timer

/* rtl/mdfm_oc_blanker.sv */
`timescale 1ns/1ps
// masks overcurrent detection for a fixed time after any phase-drive edge
module mdfm_oc_blanker
   import mdfm_pkg::*;
(
   input wire logic clk,
   input wire logic rstSyncB,
   input wire logic clkEn,
   input wire logic [PHASE_W-1:0] phaseDrive,
   input wire logic ocRaw,
   output logic ocQualified
);

   logic [PHASE_W-1:0] phase_q;
   logic [BLANK_W-1:0] blank_q;
   logic edgeSeen;

   assign edgeSeen = |(phase_q ^ phaseDrive);
   assign ocQualified = ocRaw & ~edgeSeen & (blank_q == '0);

   always_ff @(posedge clk or negedge rstSyncB) begin
      if (!rstSyncB) begin
         phase_q <= '0;
      end else if (clkEn) begin
         phase_q <= phaseDrive;
      end
   end

   always_ff @(posedge clk or negedge rstSyncB) begin
      if (!rstSyncB) begin
         blank_q <= '0;
      end else if (clkEn) begin
         if (edgeSeen) begin
            blank_q <= BLANK_W'(BLANK_CYC - 1);
         end else if (blank_q != '0) begin
            blank_q <= blank_q - 1'b1;
         end
      end
   end

endmodule : mdfm_oc_blanker

/* rtl/motor_driver_fault_manager.sv */
`timescale 1ns/1ps
module motor_driver_fault_manager
   import mdfm_pkg::*;
#(
   parameter int SLOW_CYCLES = SLOW_RETRY_CYC,
   parameter int FAST_CYCLES = FAST_RETRY_CYC
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic clkEn,
   input wire mdfm_detect_type detect,
   input wire mdfm_config_type cfg,
   input wire logic [PHASE_W-1:0] phaseDrive,
   input wire logic clear_fault_bit,
   input wire logic sleep_pin_n,
   output logic fault_out_n_o,
   output logic fault_out_n_oe_b,
   output logic bridgeEnable,
   output logic chargePumpEnable,
   output logic logicEnable,
   output logic serialEnable,
   output logic senseAmpEnable,
   output mdfm_status_type status
);

   ////////////////////////////////////////////////////////////////////////
   // reset release
   logic rstMeta_q;
   logic rstSyncB;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rstMeta_q <= 1'b0;
         rstSyncB <= 1'b0;
      end else begin
         rstMeta_q <= 1'b1;
         rstSyncB <= rstMeta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // clear-fault request: control bit or a long enough sleep-pin low pulse
   logic [9:0] sleepLow_q;
   logic sleepPrev_q;
   logic clearReq;
   logic sleepPulse;

   assign sleepPulse = sleep_pin_n & ~sleepPrev_q &
      (sleepLow_q >= 10'(RST_PULSE_CYC));
   assign clearReq = clear_fault_bit | sleepPulse;

   always_ff @(posedge clk or negedge rstSyncB) begin
      if (!rstSyncB) begin
         sleepLow_q <= '0;
         sleepPrev_q <= 1'b1;
      end else if (clkEn) begin
         sleepPrev_q <= sleep_pin_n;
         if (sleep_pin_n) begin
            sleepLow_q <= '0;
         end else if (sleepLow_q != 10'h3ff) begin
            sleepLow_q <= sleepLow_q + 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // effective configuration; pin variant pins everything but the serial fault mode to fixed values
   logic uvFast;
   logic refUvOn;
   logic [2:0] ocMode;
   logic tsFast;
   logic warnReport;
   logic serialReport;

   // pin variant forces fast retry and keeps reference detection off
   assign uvFast = cfg.pinVariant | (cfg.uvRetrySelect == UV_SEL_FAST);
   assign refUvOn = ~cfg.pinVariant & cfg.senseRefUvEnable;
   assign ocMode = cfg.pinVariant ? OC_RETRY_FAST : cfg.overcurrentMode;
   assign tsFast = cfg.pinVariant | (cfg.thermalShutdownMode == TS_FAST);
   assign warnReport = ~cfg.pinVariant & cfg.thermalWarnReportEnable;
   assign serialReport = ~cfg.serialFaultMode;

   ////////////////////////////////////////////////////////////////////////
   // overcurrent qualification
   logic ocSeen;

   mdfm_oc_blanker uBlank (
      .clk(clk),
      .rstSyncB(rstSyncB),
      .clkEn(clkEn),
      .phaseDrive(phaseDrive),
      .ocRaw(detect.overcurrent),
      .ocQualified(ocSeen)
   );

   ////////////////////////////////////////////////////////////////////////
   // retry timers: 0 reg input, 1 reg output, 2 charge pump, 3 reference,
   // 4 overcurrent, 5 thermal shutdown
   localparam int NTMR = 6;
   logic [NTMR-1:0] tmrCond;
   logic [NTMR-1:0] tmrFast;
   logic [NTMR-1:0] tmrHold;
   logic ocAuto;

   assign ocAuto = (ocMode == OC_RETRY_SLOW) | (ocMode == OC_RETRY_FAST);
   // core supply monitors have no enable at all
   assign tmrCond[0] = detect.regInputUv;
   assign tmrCond[1] = detect.regOutputUv;
   assign tmrCond[2] = detect.chargePumpUv;
   assign tmrCond[3] = detect.senseRefUv & refUvOn;
   assign tmrCond[4] = ocSeen & ocAuto;
   assign tmrCond[5] = detect.thermalShutdown;
   assign tmrFast[3:0] = {4{uvFast}};
   assign tmrFast[4] = (ocMode == OC_RETRY_FAST);
   assign tmrFast[5] = tsFast;

   genvar gi;
   generate
      for (gi = 0; gi < NTMR; gi++) begin : gTmr
         mdfm_retry_timer uTmr (
            .clk(clk),
            .rstSyncB(rstSyncB),
            .clkEn(clkEn),
            .condition(tmrCond[gi]),
            .useFast(tmrFast[gi]),
            .slowCycles(RETRY_W'(SLOW_CYCLES)),
            .fastCycles(RETRY_W'(FAST_CYCLES)),
            .holdOff(tmrHold[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // latched overcurrent (latched and report-only modes)
   logic ocLatch_q;
   logic ocLatchMode;

   assign ocLatchMode = (ocMode == OC_LATCHED) | (ocMode == OC_REPORT);

   always_ff @(posedge clk or negedge rstSyncB) begin
      if (!rstSyncB) begin
         ocLatch_q <= 1'b0;
      end else if (clkEn) begin
         if (ocSeen & ocLatchMode) begin
            ocLatch_q <= 1'b1;
         end else if (clearReq & ~detect.overcurrent) begin
            ocLatch_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // status flags, sticky unless they follow their source; a new event beats a simultaneous clear
   logic anyUv;
   logic anyOc;
   logic serialFault;
   logic anyFault;
   logic porSeen_q;
   mdfm_status_type stat_q;

   assign serialFault = detect.serialClockFault | detect.serialAddrFault;
   assign anyUv = |tmrCond[3:0];
   assign anyOc = ocSeen & (ocMode != OC_DISABLED);
   assign anyFault = anyUv | anyOc | detect.thermalShutdown |
      (serialFault & serialReport);

   always_ff @(posedge clk or negedge rstSyncB) begin
      if (!rstSyncB) begin
         porSeen_q <= 1'b0;
      end else if (clkEn) begin
         porSeen_q <= ~detect.mainSupplyUv;
      end
   end

   always_ff @(posedge clk or negedge rstSyncB) begin
      if (!rstSyncB) begin
         stat_q <= '0;
      end else if (clkEn) begin
         // supply back: power-on flag stays low until cleared
         if (detect.mainSupplyUv | (~detect.mainSupplyUv & ~porSeen_q)) begin
            stat_q.powerOnFlag <= 1'b0;
         end else if (clearReq) begin
            stat_q.powerOnFlag <= 1'b1;
         end
         if (anyFault) begin
            stat_q.faultFlag <= 1'b1;
         end else if (clearReq) begin
            stat_q.faultFlag <= 1'b0;
         end
         if (anyUv) begin
            stat_q.undervoltageFlag <= 1'b1;
         end else if (clearReq) begin
            stat_q.undervoltageFlag <= 1'b0;
         end
         // per-source supply flags follow the retry hold-off
         stat_q.regInputUvFlag <= tmrHold[0];
         stat_q.regOutputUvFlag <= tmrHold[1];
         stat_q.chargePumpUvFlag <= tmrHold[2];
         stat_q.senseRefUvFlag <= tmrHold[3];
         if (anyOc) begin
            stat_q.overcurrentFlag <= 1'b1;
         end else if (clearReq & ~ocLatch_q) begin
            stat_q.overcurrentFlag <= 1'b0;
         end
         stat_q.serialFaultFlag <= serialFault;
         if (detect.thermalWarning | detect.thermalShutdown) begin
            stat_q.overTempFlag <= 1'b1;
         end else if (clearReq) begin
            stat_q.overTempFlag <= 1'b0;
         end
         stat_q.thermalWarningFlag <= detect.thermalWarning;
         stat_q.thermalShutdownFlag <= tmrHold[5];
      end
   end

   assign status = stat_q;

   ////////////////////////////////////////////////////////////////////////
   // actions and fault pin
   logic bridgeOff;
   logic reportReq;
   logic outEn_q;
   logic logicEn_q;
   logic serialEn_q;
   logic pumpEn_q;
   logic senseEn_q;
   logic faultLow_q;

   // thermal warning never enters bridgeOff
   assign bridgeOff = tmrHold[0] | tmrHold[1] | tmrHold[2] | tmrHold[4] |
      tmrHold[5] | (ocLatch_q & (ocMode == OC_LATCHED));
   // retry hold keeps the pin low until the driver restarts
   assign reportReq = |tmrHold | ocLatch_q |
      (serialFault & serialReport) |
      (detect.thermalWarning & warnReport);

   always_ff @(posedge clk or negedge rstSyncB) begin
      if (!rstSyncB) begin
         outEn_q <= 1'b0;
         logicEn_q <= 1'b0;
         pumpEn_q <= 1'b0;
      end else if (clkEn) begin
         outEn_q <= ~detect.mainSupplyUv & ~bridgeOff;
         logicEn_q <= ~detect.mainSupplyUv;
         pumpEn_q <= ~detect.mainSupplyUv & ~tmrHold[5];
      end
   end

   always_ff @(posedge clk or negedge rstSyncB) begin
      if (!rstSyncB) begin
         serialEn_q <= 1'b0;
         senseEn_q <= 1'b0;
      end else if (clkEn) begin
         // serial link dropped for regulator faults
         serialEn_q <= ~detect.mainSupplyUv & ~tmrHold[0] & ~tmrHold[1];
         senseEn_q <= ~detect.mainSupplyUv & ~tmrHold[3];
      end
   end

   always_ff @(posedge clk or negedge rstSyncB) begin
      if (!rstSyncB) begin
         faultLow_q <= 1'b0;
      end else if (clkEn) begin
         // during lockout the logic is off and the pin is released
         faultLow_q <= reportReq & ~detect.mainSupplyUv;
      end
   end

   assign bridgeEnable = outEn_q;
   assign logicEnable = logicEn_q;
   assign chargePumpEnable = pumpEn_q;
   assign serialEnable = serialEn_q;
   assign senseAmpEnable = senseEn_q;
   assign fault_out_n_o = 1'b0;
   assign fault_out_n_oe_b = ~faultLow_q;

endmodule : motor_driver_fault_manager

/* testbench/mdfm_fault_checker_properties.sv */
`timescale 1ns/1ps
module mdfm_fault_checker
   import mdfm_pkg::*;
#(
   parameter int SLOW_CYCLES = SLOW_RETRY_CYC,
   parameter int FAST_CYCLES = FAST_RETRY_CYC
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic clkEn,
   input wire mdfm_detect_type detect,
   input wire mdfm_config_type cfg,
   input wire logic clear_fault_bit,
   input wire logic sleep_pin_n,
   input wire logic fault_out_n_oe_b,
   input wire logic bridgeEnable,
   input wire logic chargePumpEnable,
   input wire logic logicEnable,
   input wire logic serialEnable,
   input wire logic senseAmpEnable,
   input wire mdfm_status_type status
);
   logic [1:0] upCnt_q;
   logic [4:0] causeHist_q;
   logic live;
   logic cause;
   // outputs only follow inputs once the reset synchroniser lets go
   assign live = (upCnt_q == 2'h3) && clkEn;
   assign cause = detect.mainSupplyUv | detect.regInputUv |
      detect.regOutputUv | detect.chargePumpUv | detect.overcurrent |
      detect.thermalShutdown | !sleep_pin_n;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         upCnt_q <= 2'h0;
      end else if (upCnt_q != 2'h3) begin
         upCnt_q <= upCnt_q + 2'h1;
      end
   end
   // latched overcurrent takes a few stages to reach the bridge
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         causeHist_q <= 5'h00;
      end else begin
         causeHist_q <= {causeHist_q[3:0], cause};
      end
   end
   ////////////////////////////////////////
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   main_lockout_a:
      assert property (live && detect.mainSupplyUv |=> !bridgeEnable &&
         !chargePumpEnable && !logicEnable) else $error("lockout");
   uv_shutdown_a:
      assert property (live && detect.regInputUv |=> !bridgeEnable &&
         !serialEnable && !fault_out_n_oe_b && status.faultFlag &&
         status.undervoltageFlag && status.regInputUvFlag)
      else $error("input uv");
   flag_hold_a:
      assert property (live && status.undervoltageFlag &&
         !detect.mainSupplyUv && !clear_fault_bit &&
         !$past(clear_fault_bit) && $past(sleep_pin_n, 1) &&
         $past(sleep_pin_n, 2) |=> status.undervoltageFlag)
      else $error("uv flag lost");
   ref_uv_a:
      assert property (live && detect.senseRefUv && cfg.senseRefUvEnable &&
         !cfg.pinVariant |=> !senseAmpEnable && !fault_out_n_oe_b)
      else $error("ref uv");
   ref_uv_off_a:
      assert property (live && $rose(status.senseRefUvFlag) |->
         $past(cfg.senseRefUvEnable) && !$past(cfg.pinVariant))
      else $error("ref uv off");
   warn_report_a:
      assert property (live && detect.thermalWarning && !cfg.pinVariant &&
         cfg.thermalWarnReportEnable |=> !fault_out_n_oe_b)
      else $error("warn pin");
   serial_report_a:
      assert property (live && !cfg.serialFaultMode && !cfg.pinVariant &&
         (detect.serialClockFault || detect.serialAddrFault)
         |=> !fault_out_n_oe_b) else $error("serial pin");
   bridge_cause_a:
      assert property (live && $fell(bridgeEnable) |-> cause ||
         (|causeHist_q)) else $error("bridge off");
endmodule : mdfm_fault_checker

/* testbench/mdfm_controller_model.sv */
`timescale 1ns/1ps
// controller side of the fault line, with its pull-up
module mdfm_controller_model (
   input wire logic fault_out_n_o,
   input wire logic fault_out_n_oe_b,
   output logic faultLine
);
   // released line reads the pull-up, never a stale driven value
   assign faultLine = fault_out_n_oe_b ? 1'b1 : fault_out_n_o;
endmodule : mdfm_controller_model

/* testbench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   import mdfm_pkg::*;
   localparam int SLOW_CYCLES = 20;
   localparam int FAST_CYCLES = 5;
   logic clk, rst_b, clkEn, clear_fault_bit, sleep_pin_n;
   mdfm_detect_type detect;
   mdfm_config_type cfg;
   logic [PHASE_W-1:0] phaseDrive;
   logic fault_out_n_o, fault_out_n_oe_b, faultLine;
   logic bridgeEnable, chargePumpEnable, logicEnable;
   logic serialEnable, senseAmpEnable;
   mdfm_status_type status;
   int miscompares = 0;
   int comparisons = 0;
   int lim;
   logic [31:0] seed;
   logic [10:0] expQ[$];
   logic [10:0] maskQ[$];
   logic [10:0] obs;
   logic [2:0] code[7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7, 3'h0, 3'h1};
   logic [5:0] w[7] = '{6'h03, 6'h0f, 6'h00, 6'h2a, 6'h3f, 6'h03, 6'h0f};
   logic [9:0] rdet[6] = '{10'h8, 10'h4, 10'h2, 10'h2, 10'h20, 10'h20};
   logic [2:0] rcfg[6] = '{3'h0, 3'h4, 3'h2, 3'h0, 3'h1, 3'h0};
   logic [1:0] rexp[6] = '{2'h2, 2'h3, 2'h2, 2'h3, 2'h0, 2'h3};
   assign obs = {bridgeEnable, chargePumpEnable, logicEnable, serialEnable,
      senseAmpEnable, faultLine, status.faultFlag, status.undervoltageFlag,
      status.regInputUvFlag, status.powerOnFlag, status.overcurrentFlag};
   motor_driver_fault_manager #(.SLOW_CYCLES(SLOW_CYCLES),
      .FAST_CYCLES(FAST_CYCLES)) DUT (.clk, .rst_b, .clkEn, .detect, .cfg,
      .phaseDrive, .clear_fault_bit, .sleep_pin_n, .fault_out_n_o,
      .fault_out_n_oe_b, .bridgeEnable, .chargePumpEnable, .logicEnable,
      .serialEnable, .senseAmpEnable, .status);
   mdfm_controller_model ctrl (.fault_out_n_o, .fault_out_n_oe_b,
      .faultLine);
   ////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction : xs
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step
   task automatic note(input logic [10:0] m, input logic [10:0] v);
      maskQ.push_back(m);
      expQ.push_back(v);
   endtask : note
   task automatic check(input string nm, input logic [10:0] seen,
      input logic [10:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic clear_pulse();
      clear_fault_bit = 1'b1;
      step(1);
      clear_fault_bit = 1'b0;
      step(3);
   endtask : clear_pulse
   task automatic results();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : results
   ////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      logic [10:0] m;
      forever begin
         @(posedge clk);
         #2;
         while (expQ.size() > 0) begin
            m = maskQ.pop_front();
            check("outputs", obs & m, expQ.pop_front() & m);
         end
      end
   end
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      results();
   end
   initial begin
      clkEn = 1'b1;
      detect = '0;
      cfg = '0;
      phaseDrive = '0;
      clear_fault_bit = 1'b0;
      sleep_pin_n = 1'b1;
      rst_b = 1'b0;
      seed = 32'h62;
      repeat (4) @(posedge clk);
      #1;
      rst_b = 1'b1;
      step(40);
      clear_pulse();
      note(11'h7ff, 11'h7e2);
      for (int i = 0; i < 3; i++) begin
         lim = (i == 0) ? SLOW_CYCLES : FAST_CYCLES;
         cfg.pinVariant = (i == 2);
         cfg.uvRetrySelect = (i == 1) ? UV_SEL_FAST : UV_SEL_SLOW;
         detect.regInputUv = 1'b1;
         step(3);
         note(11'h4bc, 11'h01c);
         detect.regInputUv = 1'b0;
         step(lim - 2);
         detect.regInputUv = 1'b1;
         step(1);
         detect.regInputUv = 1'b0;
         step(lim - 3);
         note(11'h400, 11'h000);
         step(8);
         note(11'h4bc, 11'h4b8);
         clear_pulse();
         note(11'h018, 11'h000);
      end
      cfg.pinVariant = 1'b0;
      detect.mainSupplyUv = 1'b1;
      step(3);
      note(11'h700, 11'h000);
      detect.mainSupplyUv = 1'b0;
      step(30);
      note(11'h702, 11'h700);
      sleep_pin_n = 1'b0;
      step(RST_PULSE_CYC + 10);
      sleep_pin_n = 1'b1;
      step(3);
      note(11'h002, 11'h002);
      for (int i = 0; i < 7; i++) begin
         cfg.overcurrentMode = code[i];
         cfg.thermalShutdownMode = code[i][1:0];
         detect = mdfm_detect_type'((i < 5) ? 10'h010 : 10'h001);
         step(4);
         note(11'h420, {w[i][5], 4'h0, w[i][4], 5'h00});
         detect = '0;
         step(12);
         note(11'h420, {w[i][3], 4'h0, w[i][2], 5'h00});
         step(20);
         note(11'h420, {w[i][1], 4'h0, w[i][0], 5'h00});
         clear_pulse();
         note(11'h420, 11'h420);
      end
      cfg.overcurrentMode = OC_RETRY_FAST;
      for (int i = 0; i < 6; i++) begin
         {cfg.serialFaultMode, cfg.thermalWarnReportEnable,
            cfg.senseRefUvEnable} = rcfg[i];
         detect = mdfm_detect_type'(rdet[i]);
         step(3);
         note(11'h460, {1'b1, 3'h0, rexp[i], 5'h00});
         detect = '0;
         step(30);
         note(11'h460, 11'h460);
         clear_pulse();
      end
      // a phase edge must hide the whole overcurrent burst
      cfg.overcurrentMode = OC_LATCHED;
      repeat (4) begin
         seed = xs(seed);
         phaseDrive = phaseDrive ^ (seed[PHASE_W-1:0] | 6'h01);
         detect.overcurrent = 1'b1;
         step(BLANK_CYC - 10);
         detect.overcurrent = 1'b0;
         step(2);
      end
      note(11'h420, 11'h420);
      step(3);
      results();
   end
endmodule : tb_top
bind motor_driver_fault_manager mdfm_fault_checker #(
   .SLOW_CYCLES(SLOW_CYCLES), .FAST_CYCLES(FAST_CYCLES)) chk (.clk,
   .rst_b, .clkEn, .detect, .cfg, .clear_fault_bit, .sleep_pin_n,
   .fault_out_n_oe_b, .bridgeEnable, .chargePumpEnable, .logicEnable,
   .serialEnable, .senseAmpEnable, .status);
